// >>> pkg/cpu_state_defs.vh
// constants for the processor programmer-visible state block
`ifndef CPU_STATE_DEFS_VH
`define CPU_STATE_DEFS_VH
////////////////////////////////////////////////////////////////////////////////
// core commands, alu group (cmd[4] low)
`define CMD_LDA   5'h00
`define CMD_ADD   5'h01
`define CMD_ADC   5'h02
`define CMD_SUB   5'h03
`define CMD_SBC   5'h04
`define CMD_AND   5'h05
`define CMD_ORA   5'h06
`define CMD_EOR   5'h07
`define CMD_ASL   5'h08
`define CMD_LSR   5'h09
`define CMD_ROL   5'h0A
`define CMD_ROR   5'h0B
`define CMD_DAA   5'h0C
// core commands, register group
`define CMD_NOP   5'h10
`define CMD_LDHX  5'h11
`define CMD_PUSH  5'h12
`define CMD_PULL  5'h13
`define CMD_RSP   5'h14
`define CMD_CLI   5'h15
`define CMD_SEI   5'h16
`define CMD_JUMP  5'h17
`define CMD_FETCH 5'h18
`define CMD_IRQ   5'h19
`define CMD_RTI   5'h1A
`define CMD_WAIT  5'h1B
`define CMD_STOP  5'h1C
`define CMD_BTST  5'h1D
////////////////////////////////////////////////////////////////////////////////
// condition code layout
`define CC_V      7
`define CC_ONE1   6
`define CC_ONE0   5
`define CC_H      4
`define CC_I      3
`define CC_N      2
`define CC_Z      1
`define CC_C      0
`define CC_ONES   8'h60
`define CC_RESET  8'h68
////////////////////////////////////////////////////////////////////////////////
// reset values and vectors
`define SP_RESET   16'h00FF
`define SP_LOW_RSP 8'hFF
`define VEC_RESET  16'hFFFE
`define VEC_BREAK  16'hFFFC
`define VEC_BRKMON 16'hFEFC
`define BYTE_ZERO  8'h00
////////////////////////////////////////////////////////////////////////////////
// apb register byte offsets
`define REG_ACC   8'h00
`define REG_HX    8'h04
`define REG_SP    8'h08
`define REG_PC    8'h0C
`define REG_CCR   8'h10
`define REG_STAT  8'h14
`define REG_CTRL  8'h18
////////////////////////////////////////////////////////////////////////////////
// one-hot sequencer states
`define ST_VHI  6'b000001
`define ST_VLO  6'b000010
`define ST_RUN  6'b000100
`define ST_WAIT 6'b001000
`define ST_STOP 6'b010000
`define ST_OSC  6'b100000
`define ST_W    6
// oscillator stabilization delay in cycles
`define OSC_DELAY 16'h1000
`endif

// >>> rtl/flag_alu.v
// alu result and flag computation for the accumulator commands
`include "cpu_state_defs.vh"
module flag_alu
(
  input  wire [4:0] op_i,
  input  wire [7:0] a_i,
  input  wire [7:0] m_i,
  input  wire       c_i,
  input  wire       h_i,
  output reg  [7:0] res_o,
  output reg        v_o,
  output reg        h_o,
  output reg        c_o
);
  reg [8:0] sum;
  reg [4:0] low;
  reg [7:0] corr;

  always @*
  begin
    sum   = 9'h000;
    low   = 5'h00;
    corr  = 8'h00;
    res_o = a_i;
    v_o   = 1'b0;
    h_o   = h_i;
    c_o   = c_i;
    case (op_i)
      `CMD_LDA: res_o = m_i;
      `CMD_ADD, `CMD_ADC:
      begin
        sum   = {1'b0, a_i} + {1'b0, m_i} + {8'h00, (op_i == `CMD_ADC) & c_i};
        low   = {1'b0, a_i[3:0]} + {1'b0, m_i[3:0]} + {4'h0, (op_i == `CMD_ADC) & c_i};
        res_o = sum[7:0];
        c_o   = sum[8];
        h_o   = low[4];
        v_o   = (a_i[7] == m_i[7]) & (sum[7] != a_i[7]);
      end
      `CMD_SUB, `CMD_SBC:
      begin
        sum   = {1'b0, a_i} - {1'b0, m_i} - {8'h00, (op_i == `CMD_SBC) & c_i};
        res_o = sum[7:0];
        c_o   = sum[8];
        v_o   = (a_i[7] != m_i[7]) & (sum[7] != a_i[7]);
      end
      `CMD_AND: res_o = a_i & m_i;
      `CMD_ORA: res_o = a_i | m_i;
      `CMD_EOR: res_o = a_i ^ m_i;
      `CMD_ASL, `CMD_ROL:
      begin
        res_o = {a_i[6:0], (op_i == `CMD_ROL) & c_i};
        c_o   = a_i[7];
        v_o   = res_o[7] ^ a_i[7];
      end
      `CMD_LSR, `CMD_ROR:
      begin
        res_o = {(op_i == `CMD_ROR) & c_i, a_i[7:1]};
        c_o   = a_i[0];
        v_o   = res_o[7] ^ a_i[0];
      end
      `CMD_DAA:
      begin
        // correction chosen from half-carry, carry and the nibbles
        if (h_i || (a_i[3:0] > 4'h9))
          corr[3:0] = 4'h6;
        if (c_i || (a_i[7:4] > 4'h9) || ((a_i[7:4] > 4'h8) && (a_i[3:0] > 4'h9)))
          corr[7:4] = 4'h6;
        res_o = a_i + corr;
        c_o   = c_i | (corr[7:4] != 4'h0);
      end
      default: res_o = a_i;
    endcase
  end
endmodule // flag_alu

// >>> rtl/cpu_programmer_state.v
// programmer-visible registers, flags and low-power/break sequencing of the core
//
// The register addresses and register access over APB were left to the implementer.
`include "cpu_state_defs.vh"
//
// Contract
// - one 8-bit accumulator holds operands, results
// - 16-bit index pair from upper, lower bytes
// - reset loads stack pointer with 00FF
// - reset-stack op sets low byte FF only
// - stack pointer: push decrements, pull increments
// - program counter increments on fetch, loads jumps
// - reset fetches start address from FFFE, FFFF
// - condition code bits 6, 5 read one
// - overflow set on signed overflow, else cleared; the decimal adjust op leaves overflow unchanged
// - half-carry from bit 3 on adds
// - mask blocks interrupts; set before vector fetch
// - interrupt entry never stacks upper index byte
// - return pulls mask; priority service after clear
// - reset sets mask; clear, wait and stop ops clear it, return reloads it
// - negative follows result bit 7
// - zero set when result is 00
// - carry from add, borrow, test, shifts
// - wait clears mask, stops clock, exits
// - stop clears mask, exits after oscillator delay
// - break loads interrupt opcode, break vector
// - break starts at end of instruction
// - return ends break once request released
module cpu_programmer_state
#(
  parameter [7:0]  SWI_OPCODE = 8'h00,
  parameter [15:0] OSC_CYCLES = `OSC_DELAY
)
(
  input  wire        clk_i,
  input  wire        rst_n_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output reg         pslverr_o,
  // core command port
  input  wire        cmd_valid_i,
  input  wire [4:0]  cmd_i,
  input  wire [15:0] cmd_data_i,
  output wire        cmd_ready_o,
  // instruction boundary, interrupts, break
  input  wire        instr_done_i,
  input  wire        irq_req_i,
  input  wire        ext_irq_i,
  input  wire        brk_req_i,
  input  wire        monitor_mode_i,
  output wire        irq_take_o,
  output reg  [7:0]  ir_o,
  output reg         ir_load_o,
  output reg         in_break_o,
  output reg         cpu_clk_en_o,
  // vector fetch over internal bus
  output reg         mem_req_o,
  output reg  [15:0] mem_addr_o,
  input  wire [7:0]  mem_rdata_i,
  input  wire        mem_ack_i,
  // register views
  output wire [7:0]  acc_o,
  output wire [15:0] hx_o,
  output wire [15:0] sp_o,
  output wire [15:0] pc_o,
  output wire [7:0]  ccr_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // state
  reg  [7:0]       acc_q;
  reg  [15:0]      hx_q;
  reg  [15:0]      sp_q;
  reg  [15:0]      pc_q;
  reg  [7:0]       ccr_q;
  reg  [`ST_W-1:0] state_q;
  reg  [15:0]      osc_cnt_q;
  reg              halt_q;
  wire [7:0]       alu_res;
  wire             alu_v;
  wire             alu_h;
  wire             alu_c;
  wire             run;
  wire             brk_take;
  wire             cmd_go;
  wire             is_alu;
  wire [7:0]       ccr_rd;
  wire             apb_wr;
  wire             apb_setup;
  wire [7:0]       wbyte;
  wire [15:0]      wword;
  wire             op_logic;
  wire             upd_h;
  wire             upd_c;
  wire             upd_v;
  wire             wake_wait;
  wire             osc_done;
  wire [15:0]      brk_vec;
  wire [31:0]      stat_word;

  // register views
  assign acc_o  = acc_q;
  assign hx_o   = hx_q;
  assign sp_o   = sp_q;
  assign pc_o   = pc_q;
  assign ccr_rd = ccr_q | `CC_ONES;
  assign ccr_o  = ccr_rd;

  // command, interrupt and break acceptance
  assign run       = (state_q == `ST_RUN) & ~halt_q;
  // break waits for the last cycle of the running instruction
  assign brk_take  = run & brk_req_i & instr_done_i & ~in_break_o;
  assign irq_take_o = run & irq_req_i & instr_done_i & ~ccr_q[`CC_I] & ~brk_take;
  assign cmd_ready_o = run & ~brk_take;
  assign cmd_go    = cmd_valid_i & cmd_ready_o;
  assign is_alu    = ~cmd_i[4];

  ////////////////////////////////////////////////////////////////////////////////
  // flag update enables and sequencer helpers
  // load and logic ops keep carry, only adds touch half-carry
  assign op_logic  = (cmd_i == `CMD_LDA) | (cmd_i == `CMD_AND) |
                     (cmd_i == `CMD_ORA) | (cmd_i == `CMD_EOR);
  assign upd_h     = (cmd_i == `CMD_ADD) | (cmd_i == `CMD_ADC);
  assign upd_c     = ~op_logic;
  assign upd_v     = (cmd_i != `CMD_DAA);
  assign wake_wait = irq_req_i | ext_irq_i;
  assign osc_done  = (osc_cnt_q <= 16'h0001);
  assign brk_vec   = monitor_mode_i ? `VEC_BRKMON : `VEC_BREAK;

  // apb decode, no wait states
  assign apb_setup = psel_i & ~penable_i;
  assign apb_wr    = psel_i & penable_i & pwrite_i;
  assign pready_o  = 1'b1;
  assign wbyte     = pwdata_i[7:0];
  assign wword     = pwdata_i[15:0];
  assign stat_word = {22'h000000, in_break_o, cpu_clk_en_o, 2'b00, state_q};

  // accumulator result and flags
  flag_alu u_alu
  (
    .op_i  (cmd_i),
    .a_i   (acc_q),
    .m_i   (cmd_data_i[7:0]),
    .c_i   (ccr_q[`CC_C]),
    .h_i   (ccr_q[`CC_H]),
    .res_o (alu_res),
    .v_o   (alu_v),
    .h_o   (alu_h),
    .c_o   (alu_c)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb read path, data held from the setup cycle
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr_o <= 1'b0;
      case (paddr_i)
        `REG_ACC:  prdata_o <= {24'h000000, acc_q};
        `REG_HX:   prdata_o <= {16'h0000, hx_q};
        `REG_SP:   prdata_o <= {16'h0000, sp_q};
        `REG_PC:   prdata_o <= {16'h0000, pc_q};
        `REG_CCR:  prdata_o <= {24'h000000, ccr_rd};
        `REG_STAT: prdata_o <= stat_word;
        `REG_CTRL: prdata_o <= {31'h00000000, halt_q};
        default:
        begin
          prdata_o  <= 32'h00000000;
          pslverr_o <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers, flags and sequencer
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      acc_q        <= `BYTE_ZERO;
      hx_q         <= 16'h0000;
      sp_q         <= `SP_RESET;
      pc_q         <= 16'h0000;
      ccr_q        <= `CC_RESET;
      state_q      <= `ST_VHI;
      mem_addr_o   <= `VEC_RESET;
      mem_req_o    <= 1'b1;
      osc_cnt_q    <= 16'h0000;
      halt_q       <= 1'b0;
      ir_o         <= `BYTE_ZERO;
      ir_load_o    <= 1'b0;
      in_break_o   <= 1'b0;
      cpu_clk_en_o <= 1'b0;
    end
    else
    begin
      ir_load_o <= 1'b0;
      // sequencer
      case (state_q)
        `ST_VHI:
        begin
          if (mem_ack_i)
          begin
            pc_q[15:8] <= mem_rdata_i;
            mem_addr_o <= mem_addr_o + 16'h0001;
            state_q    <= `ST_VLO;
          end
        end
        `ST_VLO:
        begin
          if (mem_ack_i)
          begin
            pc_q[7:0]    <= mem_rdata_i;
            mem_req_o    <= 1'b0;
            cpu_clk_en_o <= 1'b1;
            state_q      <= `ST_RUN;
          end
        end
        `ST_RUN:
        begin
          if (brk_take)
          begin
            ir_o       <= SWI_OPCODE;
            ir_load_o  <= 1'b1;
            in_break_o <= 1'b1;
            mem_addr_o <= brk_vec;
            mem_req_o  <= 1'b1;
            state_q    <= `ST_VHI;
          end
          else if (cmd_go)
          begin
            if (is_alu)
            begin
              acc_q             <= alu_res;
              ccr_q[`CC_N]      <= alu_res[7];
              ccr_q[`CC_Z]      <= (alu_res == `BYTE_ZERO);
              if (upd_v)
                ccr_q[`CC_V]    <= alu_v;
              if (upd_h)
                ccr_q[`CC_H]    <= alu_h;
              if (upd_c)
                ccr_q[`CC_C]    <= alu_c;
            end
            else
            begin
              case (cmd_i)
                `CMD_LDHX:  hx_q <= cmd_data_i;
                `CMD_PUSH:  sp_q <= sp_q - 16'h0001;
                `CMD_PULL:  sp_q <= sp_q + 16'h0001;
                `CMD_RSP:   sp_q[7:0] <= `SP_LOW_RSP;
                `CMD_CLI:   ccr_q[`CC_I] <= 1'b0;
                `CMD_SEI:   ccr_q[`CC_I] <= 1'b1;
                `CMD_JUMP:  pc_q <= cmd_data_i;
                `CMD_FETCH: pc_q <= pc_q + 16'h0001;
                `CMD_BTST:  ccr_q[`CC_C] <= cmd_data_i[0];
                `CMD_IRQ:
                begin
                  // registers already stacked by the core, upper index untouched
                  ccr_q[`CC_I] <= 1'b1;
                  mem_addr_o   <= cmd_data_i;
                  mem_req_o    <= 1'b1;
                  state_q      <= `ST_VHI;
                end
                `CMD_RTI:
                begin
                  ccr_q <= cmd_data_i[7:0] | `CC_ONES;
                  if (!brk_req_i)
                    in_break_o <= 1'b0;
                end
                `CMD_WAIT:
                begin
                  ccr_q[`CC_I] <= 1'b0;
                  cpu_clk_en_o <= 1'b0;
                  state_q      <= `ST_WAIT;
                end
                `CMD_STOP:
                begin
                  ccr_q[`CC_I] <= 1'b0;
                  cpu_clk_en_o <= 1'b0;
                  state_q      <= `ST_STOP;
                end
                default: hx_q <= hx_q;
              endcase
            end
          end
        end
        `ST_WAIT:
        begin
          // any interrupt wakes, mask left clear
          if (wake_wait)
          begin
            cpu_clk_en_o <= 1'b1;
            state_q      <= `ST_RUN;
          end
        end
        `ST_STOP:
        begin
          if (ext_irq_i)
          begin
            osc_cnt_q <= OSC_CYCLES;
            state_q   <= `ST_OSC;
          end
        end
        `ST_OSC:
        begin
          // clock held off until the oscillator settles
          if (osc_done)
          begin
            cpu_clk_en_o <= 1'b1;
            state_q      <= `ST_RUN;
          end
          else
            osc_cnt_q <= osc_cnt_q - 16'h0001;
        end
        default: state_q <= `ST_VHI;
      endcase
      // software access wins over a core command in the same cycle
      if (apb_wr)
      begin
        case (paddr_i)
          `REG_ACC:  acc_q  <= wbyte;
          `REG_HX:   hx_q   <= wword;
          `REG_SP:   sp_q   <= wword;
          `REG_PC:   pc_q   <= wword;
          `REG_CCR:  ccr_q  <= wbyte | `CC_ONES;
          `REG_CTRL: halt_q <= pwdata_i[0];
          default:   halt_q <= halt_q;
        endcase
      end
    end
  end
endmodule // cpu_programmer_state

// >>> bench/cpu_programmer_state_sva.sv
// concurrent checks on the programmer-visible state block
`include "cpu_state_defs.vh"
module cpu_programmer_state_sva
#(
  parameter [7:0] SWI_OPCODE = 8'h00
)
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic        cmd_valid_i,
  input wire logic [4:0]  cmd_i,
  input wire logic [15:0] cmd_data_i,
  input wire logic        cmd_ready_o,
  input wire logic        instr_done_i,
  input wire logic        brk_req_i,
  input wire logic        monitor_mode_i,
  input wire logic        irq_take_o,
  input wire logic [7:0]  ir_o,
  input wire logic        in_break_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        mem_req_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [15:0] sp_o,
  input wire logic [7:0]  ccr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [15:0] sp_q;
  wire cmd_take = cmd_valid_i && cmd_ready_o;
  wire mask_clr = cmd_take && (cmd_i == `CMD_CLI || cmd_i == `CMD_RTI || cmd_i == `CMD_WAIT
    || cmd_i == `CMD_STOP) || psel_i && penable_i && pwrite_i && paddr_i == `REG_CCR;
  always @(posedge clk_i)
    sp_q <= sp_o;
////////////////////////////////////////////////////////////////////////////////
  reset_state_a: assert property
    ($rose(rst_n_i) |-> sp_o == `SP_RESET && ccr_o[`CC_I] && mem_addr_o == `VEC_RESET)
    else $error("reset state wrong");
  ccr_ones_a: assert property (ccr_o[`CC_ONE1:`CC_ONE0] == 2'b11)
    else $error("fixed condition code bits not one");
  rsp_low_a: assert property
    (cmd_take && cmd_i == `CMD_RSP |=> sp_o == {sp_q[15:8], `SP_LOW_RSP})
    else $error("stack reset op wrong");
  stack_step_a: assert property
    (cmd_take && (cmd_i == `CMD_PUSH || cmd_i == `CMD_PULL)
     |=> sp_o == ($past(cmd_i) == `CMD_PUSH ? sp_q - 16'h0001 : sp_q + 16'h0001))
    else $error("stack pointer step wrong");
  mask_clear_a: assert property ($fell(ccr_o[`CC_I]) |-> $past(mask_clr))
    else $error("mask cleared without cause");
  irq_mask_a: assert property (irq_take_o |-> !ccr_o[`CC_I] && instr_done_i)
    else $error("interrupt taken while masked");
  irq_entry_a: assert property
    (cmd_take && cmd_i == `CMD_IRQ |=> ccr_o[`CC_I] && mem_req_o
     && mem_addr_o == $past(cmd_data_i))
    else $error("interrupt entry wrong");
  low_power_a: assert property
    (cmd_take && (cmd_i == `CMD_WAIT || cmd_i == `CMD_STOP) |=> !cpu_clk_en_o && !ccr_o[`CC_I])
    else $error("low power entry wrong");
  brk_entry_a: assert property
    ($rose(in_break_o) |-> $past(brk_req_i) && $past(instr_done_i) && ir_o == SWI_OPCODE
     && mem_addr_o == ($past(monitor_mode_i) ? `VEC_BRKMON : `VEC_BREAK))
    else $error("break entry wrong");
  brk_hold_a: assert property (in_break_o && brk_req_i |=> in_break_o)
    else $error("break left while requested");
  push_seen_c: cover property (cmd_take && cmd_i == `CMD_PUSH);
  irq_seen_c: cover property (irq_take_o);
  brk_seen_c: cover property ($rose(in_break_o));
endmodule // cpu_programmer_state_sva

bind cpu_programmer_state cpu_programmer_state_sva #(.SWI_OPCODE(SWI_OPCODE)) i_sva (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
  .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .instr_done_i(instr_done_i),
  .brk_req_i(brk_req_i), .monitor_mode_i(monitor_mode_i), .irq_take_o(irq_take_o),
  .ir_o(ir_o), .in_break_o(in_break_o), .cpu_clk_en_o(cpu_clk_en_o), .mem_req_o(mem_req_o),
  .mem_addr_o(mem_addr_o), .sp_o(sp_o), .ccr_o(ccr_o));

// >>> bench/vec_mem_model.sv
// byte memory answering the block's vector fetches
module vec_mem_model
(
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        mem_req_i,
  input  wire logic [15:0] mem_addr_i,
  output logic      [7:0]  mem_rdata_o,
  output logic             mem_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_q = 4'h0;
  initial mem_ack_o = 1'b0;
  initial mem_rdata_o = 8'h00;
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    case (a)
      16'hFFFE: byte_at = 8'h12;
      16'hFFFF: byte_at = 8'h34;
      16'hFFFC: byte_at = 8'h56;
      16'hFFFD: byte_at = 8'h78;
      16'hFEFC: byte_at = 8'h9A;
      16'hFEFD: byte_at = 8'hBC;
      default:  byte_at = a[7:0];
    endcase
  endfunction
  // data toggles while no request is pending and after each byte, holds during wait states
  always @(posedge clk_i)
  begin
    if (mem_ack_o || !mem_req_i)
    begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      wait_q <= 4'h0;
    end
    else if (wait_q >= (slow_i ? 4'h5 : 4'h0))
    begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= byte_at(mem_addr_i);
    end
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule // vec_mem_model

// >>> bench/cpu_programmer_state_tb.sv
// self-checking bench for the programmer-visible state block
`include "cpu_state_defs.vh"
module cpu_programmer_state_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] SOFTWARE_INTERRUPT_OP = 8'h3C;
  localparam int OSC = 4;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic        cmd_valid_i = 1'b0, instr_done_i = 1'b0, irq_req_i = 1'b0, ext_irq_i = 1'b0;
  logic        brk_req_i = 1'b0, monitor_mode_i = 1'b0, slow = 1'b0, rerr;
  logic [7:0]  paddr_i = 8'h00;
  logic [4:0]  cmd_i = 5'h00;
  logic [15:0] cmd_data_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h0, rdata, prdata_o;
  logic        pready_o, pslverr_o, cmd_ready_o, irq_take_o, ir_load_o, in_break_o;
  logic        cpu_clk_en_o, mem_req_o, mem_ack_i;
  logic [7:0]  ir_o, mem_rdata_i, acc_o, ccr_o;
  logic [15:0] mem_addr_o, hx_o, sp_o, pc_o;
  int          n_errors = 0, n_checks = 0;
  // acc/flag table: command, operand, accumulator, flag mask, flags
  logic [36:0] alu_tbl [20] = '{
    {`CMD_LDA, 8'h0F, 8'h0F, 8'h86, 8'h00}, {`CMD_ADD, 8'h01, 8'h10, 8'h97, 8'h10},
    {`CMD_ADD, 8'h70, 8'h80, 8'h97, 8'h84}, {`CMD_ADD, 8'h80, 8'h00, 8'h97, 8'h83},
    {`CMD_SUB, 8'h01, 8'hFF, 8'h87, 8'h05}, {`CMD_AND, 8'h0F, 8'h0F, 8'h86, 8'h00},
    {`CMD_LDA, 8'h00, 8'h00, 8'h86, 8'h02}, {`CMD_BTST, 8'h01, 8'h00, 8'h01, 8'h01},
    {`CMD_LDA, 8'h81, 8'h81, 8'h86, 8'h04}, {`CMD_ASL, 8'h00, 8'h02, 8'h87, 8'h81},
    {`CMD_ADC, 8'h01, 8'h04, 8'h97, 8'h00}, {`CMD_LDA, 8'h09, 8'h09, 8'h86, 8'h00},
    {`CMD_ADD, 8'h09, 8'h12, 8'h97, 8'h10}, {`CMD_DAA, 8'h00, 8'h18, 8'h07, 8'h00},
    {`CMD_SBC, 8'h19, 8'hFF, 8'h87, 8'h05}, {`CMD_ROR, 8'h00, 8'hFF, 8'h87, 8'h05},
    {`CMD_LSR, 8'h00, 8'h7F, 8'h87, 8'h81}, {`CMD_ROL, 8'h00, 8'hFF, 8'h87, 8'h84},
    {`CMD_EOR, 8'hFF, 8'h00, 8'h86, 8'h02}, {`CMD_ORA, 8'h80, 8'h80, 8'h86, 8'h04}};
  always #5 clk_i = ~clk_i;
  cpu_programmer_state #(.SWI_OPCODE(SOFTWARE_INTERRUPT_OP), .OSC_CYCLES(16'h0004)) i_cpu_programmer_state (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .instr_done_i(instr_done_i),
    .irq_req_i(irq_req_i), .ext_irq_i(ext_irq_i), .brk_req_i(brk_req_i),
    .monitor_mode_i(monitor_mode_i), .irq_take_o(irq_take_o), .ir_o(ir_o),
    .ir_load_o(ir_load_o), .in_break_o(in_break_o), .cpu_clk_en_o(cpu_clk_en_o),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_rdata_i(mem_rdata_i),
    .mem_ack_i(mem_ack_i), .acc_o(acc_o), .hx_o(hx_o), .sp_o(sp_o), .pc_o(pc_o), .ccr_o(ccr_o));
  vec_mem_model i_vec_mem_model (.clk_i(clk_i), .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i));
////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(inout int n);
    @(negedge clk_i);
    n++;
    if (n > 300)
    begin
      n_errors++;
      $display("wrong value at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
    begin
      step(n);
      @(posedge clk_i);
    end
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic cmd(input logic [4:0] c, input logic [15:0] d);
    int n = 0;
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    cmd_data_i <= d;
    step(n);
    while (cmd_ready_o !== 1'b1) step(n);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic wait_ready();
    int n = 0;
    while (cmd_ready_o !== 1'b1) step(n);
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wait_ready();
    check(pc_o, 16'h1234);
    check(sp_o, `SP_RESET);
    check(ccr_o, `CC_RESET);
    apb(1'b0, `REG_SP, 32'h0);
    check(rdata, 32'h000000FF);
    apb(1'b1, `REG_CCR, 32'h0);
    check(ccr_o, `CC_ONES);
    apb(1'b0, 8'h1C, 32'h0);
    check({rerr, rdata}, {1'b1, 32'h0});
    $display("reset test done");
  endtask
  task automatic t_alu();
    for (int i = 0; i < 20; i++)
    begin
      cmd(alu_tbl[i][36:32], {8'h00, alu_tbl[i][31:24]});
      check(acc_o, alu_tbl[i][23:16]);
      check(ccr_o[7:4] & alu_tbl[i][15:12], alu_tbl[i][7:4]);
      check(ccr_o[3:0] & alu_tbl[i][11:8], alu_tbl[i][3:0]);
    end
    $display("alu test done");
  endtask
  task automatic t_regs();
    apb(1'b1, `REG_SP, 32'h0234);
    cmd(`CMD_RSP, 16'h0);
    check(sp_o, 16'h02FF);
    cmd(`CMD_PUSH, 16'h0);
    check(sp_o, 16'h02FE);
    cmd(`CMD_PULL, 16'h0);
    check(sp_o, 16'h02FF);
    cmd(`CMD_LDHX, 16'hA55A);
    apb(1'b0, `REG_HX, 32'h0);
    check(rdata, 32'h0000A55A);
    cmd(`CMD_JUMP, 16'h3FFF);
    cmd(`CMD_FETCH, 16'h0);
    check(pc_o, 16'h4000);
    apb(1'b1, `REG_CTRL, 32'h00000001);
    check(cmd_ready_o, 1'b0);
    apb(1'b0, `REG_STAT, 32'h0);
    check(rdata, 32'h00000104);
    apb(1'b1, `REG_CTRL, 32'h0);
    $display("register test done");
  endtask
  task automatic t_irq();
    slow = 1'b1;
    cmd(`CMD_CLI, 16'h0);
    check(ccr_o[`CC_I], 1'b0);
    @(posedge clk_i);
    irq_req_i <= 1'b1;
    instr_done_i <= 1'b1;
    @(negedge clk_i);
    check(irq_take_o, 1'b1);
    cmd(`CMD_SEI, 16'h0);
    check(irq_take_o, 1'b0);
    @(posedge clk_i);
    irq_req_i <= 1'b0;
    instr_done_i <= 1'b0;
    cmd(`CMD_CLI, 16'h0);
    cmd(`CMD_PUSH, 16'h0);
    cmd(`CMD_IRQ, 16'hFFF0);
    check(ccr_o[`CC_I], 1'b1);
    wait_ready();
    check(pc_o, 16'hF0F1);
    check({hx_o, sp_o}, {16'hA55A, 16'h02FE});
    cmd(`CMD_RTI, 16'h0);
    check(ccr_o, `CC_ONES);
    slow = 1'b0;
    $display("interrupt test done");
  endtask
  task automatic t_break();
    int n;
    for (int m = 0; m < 2; m++)
    begin
      n = 0;
      @(posedge clk_i);
      monitor_mode_i <= m[0];
      brk_req_i <= 1'b1;
      repeat (3) @(negedge clk_i);
      check(in_break_o, 1'b0);
      @(posedge clk_i);
      instr_done_i <= 1'b1;
      while (in_break_o !== 1'b1) step(n);
      check({ir_load_o, ir_o}, {1'b1, SOFTWARE_INTERRUPT_OP});
      @(posedge clk_i);
      instr_done_i <= 1'b0;
      wait_ready();
      check(pc_o, m ? 16'h9ABC : 16'h5678);
      cmd(`CMD_RTI, 16'h0);
      check(in_break_o, 1'b1);
      @(posedge clk_i);
      brk_req_i <= 1'b0;
      cmd(`CMD_RTI, 16'h0);
      check(in_break_o, 1'b0);
    end
    $display("break test done");
  endtask
  task automatic t_low_power();
    int n = 0;
    cmd(`CMD_SEI, 16'h0);
    cmd(`CMD_WAIT, 16'h0);
    check({cpu_clk_en_o, ccr_o[`CC_I]}, 2'b00);
    @(posedge clk_i);
    irq_req_i <= 1'b1;
    while (cpu_clk_en_o !== 1'b1) step(n);
    check(ccr_o[`CC_I], 1'b0);
    @(posedge clk_i);
    irq_req_i <= 1'b0;
    cmd(`CMD_SEI, 16'h0);
    cmd(`CMD_STOP, 16'h0);
    check({cpu_clk_en_o, ccr_o[`CC_I]}, 2'b00);
    n = 0;
    @(posedge clk_i);
    ext_irq_i <= 1'b1;
    while (cpu_clk_en_o !== 1'b1) step(n);
    check({n >= OSC, ccr_o[`CC_I]}, 2'b10);
    @(posedge clk_i);
    ext_irq_i <= 1'b0;
    cmd(`CMD_WAIT, 16'h0);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    wait_ready();
    check({ccr_o, pc_o}, {`CC_RESET, 16'h1234});
    $display("low power test done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_alu();
    t_regs();
    t_irq();
    t_break();
    t_low_power();
    give_verdict();
  end
endmodule // cpu_programmer_state_tb
